// ### shared/dac_setup_pkg.sv
package dac_setup_pkg;
  localparam int NUM_CH   = 6;
  localparam int NUM_PATH = 8;
  localparam int NUM_LANE = 8;

  // Device register offsets
  localparam logic [11:0] A_PAGE       = 12'h008;
  localparam logic [11:0] A_SYNC_MODE  = 12'h03A;
  localparam logic [11:0] A_ROTATION   = 12'h03B;
  localparam logic [11:0] A_MAIN_CFG   = 12'h112;
  localparam logic [11:0] A_MAIN_UPD   = 12'h113;
  localparam logic [11:0] A_MAIN_FTW   = 12'h114;
  localparam logic [11:0] A_MAIN_PH    = 12'h11C;
  localparam logic [11:0] A_MAIN_MOD   = 12'h124;
  localparam logic [11:0] A_MAIN_DELTA = 12'h12A;
  localparam logic [11:0] A_CH_CFG     = 12'h130;
  localparam logic [11:0] A_CH_UPD     = 12'h131;
  localparam logic [11:0] A_CH_FTW     = 12'h132;
  localparam logic [11:0] A_CH_PH      = 12'h138;
  localparam logic [11:0] A_CH_MOD     = 12'h13A;
  localparam logic [11:0] A_CH_DELTA   = 12'h140;
  localparam logic [11:0] A_CH_GAIN    = 12'h146;
  localparam logic [11:0] A_PORT_EN    = 12'h1DE;
  localparam logic [11:0] A_SERDES_PWR = 12'h200;
  localparam logic [11:0] A_LANE_PD    = 12'h201;
  localparam logic [11:0] A_SYNC_DRV   = 12'h203;
  localparam logic [11:0] A_SYNC_FMT0  = 12'h253;
  localparam logic [11:0] A_SYNC_FMT1  = 12'h254;
  localparam logic [11:0] A_PLL_CTRL   = 12'h280;
  localparam logic [11:0] A_PLL_STAT   = 12'h281;
  localparam logic [11:0] A_LINK_CTRL  = 12'h300;
  localparam logic [11:0] A_XBAR       = 12'h308;
  localparam logic [11:0] A_TXEN_FEAT  = 12'h596;

  // Values after reset
  localparam logic [7:0]  PAGE_RST       = 8'hFF;
  localparam logic [7:0]  SYNC_MODE_RST  = 8'h10;
  localparam logic [7:0]  ROTATION_RST   = 8'hB0;
  localparam logic [7:0]  MAIN_CFG_RST   = 8'h01;
  localparam logic [7:0]  CH_CFG_RST     = 8'h00;
  localparam logic [11:0] GAIN_RST       = 12'h800;
  localparam logic [7:0]  PORT_EN_RST    = 8'h03;
  localparam logic [7:0]  SERDES_PWR_RST = 8'h01;
  localparam logic [7:0]  SYNC_DRV_RST   = 8'h03;
  localparam logic [7:0]  SYNC_FMT_RST   = 8'h01;
  localparam logic [7:0]  ZERO_RST       = 8'h00;

  // Field positions
  localparam int CH_NCO_EN_BIT   = 6;
  localparam int MAIN_NCO_EN_BIT = 3;
  localparam int MOD_EN_BIT      = 2;
  localparam int SIDEBAND_BIT    = 1;
  localparam int TEST_TONE_BIT   = 0;
  localparam int UPDATE_BIT      = 0;
  localparam int PLL_LOCK_BIT    = 0;
  localparam int SYNC_LOGIC_BIT  = 7;
  localparam int ONESHOT_BIT     = 1;
  localparam int ROT_DONE_BIT    = 4;
  localparam int LINK_MODE_BIT   = 3;
  localparam int LINK_PAGE_BIT   = 2;
  localparam int SYNC_DRV0_BIT   = 1;
  localparam int SYNC_DRV1_BIT   = 0;
  localparam int FMT_LVDS_BIT    = 0;

  // Values the controller writes
  localparam logic [7:0] V_SERDES_ON     = 8'h00;
  localparam logic [7:0] V_PLL_START0    = 8'h05;
  localparam logic [7:0] V_PLL_START1    = 8'h01;
  localparam logic [7:0] V_ROTATION      = 8'hF1;
  localparam logic [7:0] V_ONESHOT       = 8'h02;
  localparam logic [7:0] V_LINK_SINGLE   = 8'h01;
  localparam logic [7:0] V_LINK_DUAL     = 8'h0B;
  localparam logic [7:0] V_SYNCDRV_SINGLE = 8'h01;
  localparam logic [7:0] V_SYNCDRV_DUAL  = 8'h00;

  // Timing
  localparam int SERDES_WAIT_MS     = 100;
  localparam int CLK_HZ             = 50_000_000;
  localparam int SERDES_WAIT_CYCLES = SERDES_WAIT_MS * (CLK_HZ / 1000);

  // Controller software registers
  localparam logic [3:0] SW_CTRL   = 4'h0;
  localparam logic [3:0] SW_DADDR  = 4'h1;
  localparam logic [3:0] SW_DWRITE = 4'h2;
  localparam logic [3:0] SW_DREAD  = 4'h3;

  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_SYNCDRV = 4'h1,
    S_PWR     = 4'h2,
    S_WAIT    = 4'h3,
    S_PLL0    = 4'h4,
    S_PLL1    = 4'h5,
    S_POLL    = 4'h6,
    S_POLL_W  = 4'h7,
    S_POLL_C  = 4'h8,
    S_ROT     = 4'h9,
    S_MODE    = 4'hA,
    S_SYSREF  = 4'hB,
    S_LINK    = 4'hC,
    S_DRD_W   = 4'hD,
    S_DRD_C   = 4'hE
  } seq_state_t;
endpackage

// ### shared/dac_setup_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dac_setup_if;
  logic [11:0] cfg_addr;
  logic [7:0]  cfg_wdata;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [7:0]  cfg_rdata;
  logic        sysref;
  logic [1:0]  sync_req_n;
  logic [1:0]  sync_req_oe;

  modport dev  (input cfg_addr, cfg_wdata, cfg_wr, cfg_rd, sysref, output cfg_rdata, sync_req_n, sync_req_oe);
  modport host (output cfg_addr, cfg_wdata, cfg_wr, cfg_rd, sysref, input cfg_rdata, sync_req_n, sync_req_oe);
endinterface
`default_nettype wire

// ### verilog/dac_setup_regs.sv
// Function
// - Channel page bit selects channel; writes broadcast
// - Main page bits select DAC paths
// - Twelve-bit channel gain over two bytes
// - Channel NCO config: enable, modulus, sideband, tone
// - Channel tuning word: six bytes, LSB first
// - Channel phase offset: two bytes, low first
// - Channel modulus and delta: six bytes each
// - Channel update bit loads staged words together
// - Main NCO config: enable, modulus, sideband
// - Main tuning word: six bytes, LSB first
// - Main phase offset: two bytes, low first
// - Main modulus and delta: six bytes each
// - Main update bit loads staged words together
// - Lane power-down bit per serial lane
// - Sync driver bits power down request outputs
// - Format bit: one LVDS, zero CMOS
// - Host powers SERDES, waits, starts PLL
// - PLL status bit zero shows lock
// - Crossbar fields pick physical source lanes
// - Rotation then one-shot mode arms sync
// - Partner sends SYSREF edges once armed
// - Link control: mode, page, enables
`timescale 1ns/1ps
`default_nettype none
module dac_setup_regs
  import dac_setup_pkg::*;
(
  input  wire logic                        clk,               // System clock
  input  wire logic                        sys_rst,           // Synchronous reset
  dac_setup_if.dev                         link,              // Register port and sync link
  input  wire logic                        serdes_pll_locked, // Raw PLL lock level
  input  wire logic [1:0]                  link_synced,       // Deframer lock per link
  output wire logic [NUM_CH-1:0][11:0]     ch_gain,           // Channel gain codes
  output wire logic [NUM_CH-1:0]           ch_test_tone,      // Channel test tone enables
  output wire logic [NUM_PATH-1:0]         nco_en,            // NCO enable, paths 6-7 main
  output wire logic [NUM_PATH-1:0]         nco_mod_en,        // Modulus mode per path
  output wire logic [NUM_PATH-1:0]         nco_lower_sb,      // Lower sideband per path
  output wire logic [NUM_PATH-1:0][47:0]   nco_ftw,           // Active tuning words
  output wire logic [NUM_PATH-1:0][15:0]   nco_phase,         // Active phase offsets
  output wire logic [NUM_PATH-1:0][47:0]   nco_modulus,       // Modulus words
  output wire logic [NUM_PATH-1:0][47:0]   nco_delta,         // Delta words
  output logic [7:0]                       lane_pd,           // Lane receiver power-down
  output logic [7:0]                       serdes_pwr,        // SERDES block power control
  output logic [7:0]                       serdes_pll_ctrl,   // SERDES PLL control
  output logic [1:0]                       sync_out_lvds,     // Request output style
  output logic [NUM_LANE-1:0][2:0]         lane_source,       // Crossbar sources
  output logic                             link_dual,         // Dual-link mode
  output logic                             link_page,         // Link being paged
  output logic [1:0]                       link_enable,       // Link enables
  output logic                             sync_align,        // One-cycle alignment pulse
  output logic [7:0]                       port_enable,       // Control port enables
  output logic [7:0]                       txen_feature       // Transmit enable feature
);

  logic [7:0]  page;
  logic [7:0]  sync_mode;
  logic [7:0]  rotation;
  logic [7:0]  sync_drv;
  logic [7:0]  link_ctrl;
  logic        lock_meta;
  logic        lock_sync;
  logic [7:0]  next_rdata;
  logic [NUM_PATH-1:0][47:0] sh_ftw;
  logic [NUM_PATH-1:0][15:0] sh_ph;
  logic [NUM_PATH-1:0][7:0]  cfg_a;
  logic [2:0]  ch_rd;
  logic [2:0]  main_rd;
  logic        sync_event;

  wire [11:0] a  = link.cfg_addr;
  wire [7:0]  d  = link.cfg_wdata;
  wire        wr = link.cfg_wr;

  function automatic logic in6(input logic [11:0] x, input logic [11:0] base);
    return (x >= base) && (x < base + 12'h006);
  endfunction

  function automatic logic [47:0] put48(input logic [47:0] w, input logic [2:0] i, input logic [7:0] b);
    logic [47:0] r;
    r = w;
    r[i*8 +: 8] = b;
    return r;
  endfunction

  function automatic logic [7:0] get48(input logic [47:0] w, input logic [2:0] i);
    return w[i*8 +: 8];
  endfunction

  // Paths 0-5 are channels, 6-7 main DACs, so page bit i selects path i
  for (genvar i = 0; i < NUM_PATH; i++) begin : g_path
    localparam bit          IS_CH = (i < NUM_CH);
    localparam logic [11:0] B_CFG = IS_CH ? A_CH_CFG : A_MAIN_CFG;
    localparam logic [11:0] B_UPD = IS_CH ? A_CH_UPD : A_MAIN_UPD;
    localparam logic [11:0] B_FTW = IS_CH ? A_CH_FTW : A_MAIN_FTW;
    localparam logic [11:0] B_PH  = IS_CH ? A_CH_PH : A_MAIN_PH;
    localparam logic [11:0] B_MOD = IS_CH ? A_CH_MOD : A_MAIN_MOD;
    localparam logic [11:0] B_DLT = IS_CH ? A_CH_DELTA : A_MAIN_DELTA;
    localparam logic [7:0]  C_RST = IS_CH ? CH_CFG_RST : MAIN_CFG_RST;
    localparam int          EN_B  = IS_CH ? CH_NCO_EN_BIT : MAIN_NCO_EN_BIT;
    logic [7:0]  cfg;
    logic [47:0] ftw;
    logic [15:0] ph;
    logic [47:0] modu;
    logic [47:0] dlt;
    logic [47:0] sftw;
    logic [15:0] sph;
    wire         sel = wr && page[i];

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        cfg       <= C_RST;
        sftw      <= '0;
        sph       <= '0;
        ftw       <= '0;
        ph        <= '0;
        modu      <= '0;
        dlt       <= '0;
      end else if (sel) begin
        if (a == B_CFG)
          cfg <= d;
        if (in6(a, B_FTW))
          sftw <= put48(sftw, 3'(a - B_FTW), d);
        if (a == B_PH)
          sph[7:0] <= d;
        if (a == B_PH + 12'h001)
          sph[15:8] <= d;
        if (in6(a, B_MOD))
          modu <= put48(modu, 3'(a - B_MOD), d);
        if (in6(a, B_DLT))
          dlt <= put48(dlt, 3'(a - B_DLT), d);
        // Staged words reach the oscillator together, never half-written
        if (a == B_UPD && d[UPDATE_BIT]) begin
          ftw <= sftw;
          ph  <= sph;
        end
      end
    end

    assign cfg_a[i]        = cfg;
    assign sh_ftw[i]       = sftw;
    assign sh_ph[i]        = sph;
    assign nco_en[i]       = cfg[EN_B];
    assign nco_mod_en[i]   = cfg[MOD_EN_BIT];
    assign nco_lower_sb[i] = cfg[SIDEBAND_BIT];
    assign nco_ftw[i]      = ftw;
    assign nco_phase[i]    = ph;
    assign nco_modulus[i]  = modu;
    assign nco_delta[i]    = dlt;

    if (IS_CH) begin : g_gain
      logic [11:0] gain;
      always_ff @(posedge clk) begin
        if (sys_rst)
          gain <= GAIN_RST;
        else if (sel && a == A_CH_GAIN)
          gain[7:0] <= d;
        else if (sel && a == A_CH_GAIN + 12'h001)
          gain[11:8] <= d[3:0];
      end
      assign ch_gain[i]      = gain;
      assign ch_test_tone[i] = cfg[TEST_TONE_BIT];
    end
  end

  // One-shot alignment: arm consumed by the SYSREF edge, done flag set
  assign sync_event = link.sysref && rotation[SYNC_LOGIC_BIT] && sync_mode[ONESHOT_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_mode  <= SYNC_MODE_RST;
      sync_align <= 1'b0;
    end else begin
      sync_align <= sync_event;
      // Hardware set wins over a software write in the same cycle
      if (sync_event) begin
        sync_mode              <= wr && a == A_SYNC_MODE ? d : sync_mode;
        sync_mode[ROT_DONE_BIT] <= 1'b1;
        sync_mode[ONESHOT_BIT]  <= 1'b0;
      end else if (wr && a == A_SYNC_MODE) begin
        sync_mode <= d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      page         <= PAGE_RST;
      rotation     <= ROTATION_RST;
      lane_pd      <= ZERO_RST;
      serdes_pwr   <= SERDES_PWR_RST;
      serdes_pll_ctrl <= ZERO_RST;
      sync_drv     <= SYNC_DRV_RST;
      sync_out_lvds <= {SYNC_FMT_RST[FMT_LVDS_BIT], SYNC_FMT_RST[FMT_LVDS_BIT]};
      link_ctrl    <= ZERO_RST;
      lane_source  <= '0;
      port_enable  <= PORT_EN_RST;
      txen_feature <= ZERO_RST;
    end else if (wr) begin
      case (a)
        A_PAGE:       page <= d;
        A_ROTATION:   rotation <= d;
        A_LANE_PD:    lane_pd <= d;
        A_SERDES_PWR: serdes_pwr <= d;
        A_PLL_CTRL:   serdes_pll_ctrl <= d;
        A_SYNC_DRV:   sync_drv <= d;
        A_SYNC_FMT0:  sync_out_lvds[0] <= d[FMT_LVDS_BIT];
        A_SYNC_FMT1:  sync_out_lvds[1] <= d[FMT_LVDS_BIT];
        A_LINK_CTRL:  link_ctrl <= d;
        A_PORT_EN:    port_enable <= d;
        A_TXEN_FEAT:  txen_feature <= d;
        default: begin
          for (int k = 0; k < NUM_LANE / 2; k++) begin
            if (a == A_XBAR + 12'(k)) begin
              lane_source[2*k]   <= d[2:0];
              lane_source[2*k+1] <= d[5:3];
            end
          end
        end
      endcase
    end
  end

  assign link_dual   = link_ctrl[LINK_MODE_BIT];
  assign link_page   = link_ctrl[LINK_PAGE_BIT];
  assign link_enable = link_ctrl[1:0];

  // Lock arrives from the analog PLL, outside this clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      lock_meta <= serdes_pll_locked;
      lock_sync <= lock_meta;
    end
  end

  // Request held low while a link is enabled and not yet locked
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.sync_req_n  <= 2'b11;
      link.sync_req_oe <= 2'b00;
    end else begin
      link.sync_req_n  <= ~(link_ctrl[1:0] & ~link_synced);
      link.sync_req_oe <= {~sync_drv[SYNC_DRV1_BIT], ~sync_drv[SYNC_DRV0_BIT]};
    end
  end

  // Reads report the lowest selected channel or main path; with none selected, channel 0 and main path 7
  always_comb begin
    ch_rd   = 3'd0;
    main_rd = page[6] ? 3'd6 : 3'd7;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (page[k])
        ch_rd = 3'(k);
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (in6(a, A_CH_FTW))
      next_rdata = get48(sh_ftw[ch_rd], 3'(a - A_CH_FTW));
    else if (in6(a, A_CH_MOD))
      next_rdata = get48(nco_modulus[ch_rd], 3'(a - A_CH_MOD));
    else if (in6(a, A_CH_DELTA))
      next_rdata = get48(nco_delta[ch_rd], 3'(a - A_CH_DELTA));
    else if (in6(a, A_MAIN_FTW))
      next_rdata = get48(sh_ftw[main_rd], 3'(a - A_MAIN_FTW));
    else if (in6(a, A_MAIN_MOD))
      next_rdata = get48(nco_modulus[main_rd], 3'(a - A_MAIN_MOD));
    else if (in6(a, A_MAIN_DELTA))
      next_rdata = get48(nco_delta[main_rd], 3'(a - A_MAIN_DELTA));
    else if (a >= A_XBAR && a < A_XBAR + 12'h004)
      next_rdata = {2'b00, lane_source[{a[1:0], 1'b1}], lane_source[{a[1:0], 1'b0}]};
    else begin
      case (a)
        A_PAGE:               next_rdata = page;
        A_SYNC_MODE:          next_rdata = sync_mode;
        A_ROTATION:           next_rdata = rotation;
        A_CH_CFG:             next_rdata = cfg_a[ch_rd];
        A_MAIN_CFG:           next_rdata = cfg_a[main_rd];
        A_CH_PH:              next_rdata = sh_ph[ch_rd][7:0];
        A_CH_PH + 12'h001:    next_rdata = sh_ph[ch_rd][15:8];
        A_MAIN_PH:            next_rdata = sh_ph[main_rd][7:0];
        A_MAIN_PH + 12'h001:  next_rdata = sh_ph[main_rd][15:8];
        A_CH_GAIN:            next_rdata = ch_gain[ch_rd][7:0];
        A_CH_GAIN + 12'h001:  next_rdata = {4'h0, ch_gain[ch_rd][11:8]};
        A_PORT_EN:            next_rdata = port_enable;
        A_SERDES_PWR:         next_rdata = serdes_pwr;
        A_LANE_PD:            next_rdata = lane_pd;
        A_SYNC_DRV:           next_rdata = sync_drv;
        A_SYNC_FMT0:          next_rdata = {7'h00, sync_out_lvds[0]};
        A_SYNC_FMT1:          next_rdata = {7'h00, sync_out_lvds[1]};
        A_PLL_CTRL:           next_rdata = serdes_pll_ctrl;
        A_PLL_STAT:           next_rdata = {7'h00, lock_sync};
        A_LINK_CTRL:          next_rdata = link_ctrl;
        A_TXEN_FEAT:          next_rdata = txen_feature;
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      link.cfg_rdata <= 8'h00;
    else if (link.cfg_rd)
      link.cfg_rdata <= next_rdata;
  end
endmodule
`default_nettype wire

// ### verilog/dac_setup_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module dac_setup_sequencer
  import dac_setup_pkg::*;
#(
  parameter int WAIT_CYCLES = dac_setup_pkg::SERDES_WAIT_CYCLES
)(
  input  wire logic        clk,      // System clock
  input  wire logic        sys_rst,  // Synchronous reset
  dac_setup_if.host        link,     // Device register port and sync link
  input  wire logic [3:0]  sw_addr,  // Software register address
  input  wire logic [15:0] sw_wdata, // Software write data
  input  wire logic        sw_wr,    // Software write strobe
  input  wire logic        sw_rd,    // Software read strobe
  output logic [15:0]      sw_rdata, // Read data, cycle after strobe
  output logic             busy      // Sequence or device read in progress
);

  seq_state_t  state;
  logic        dual;
  logic        subclass1;
  logic        done;
  logic [11:0] daddr;
  logic [7:0]  dread;
  logic        dread_valid;
  logic [22:0] wait_cnt;

  wire start  = sw_wr && sw_addr == SW_CTRL && sw_wdata[0];
  wire dwrite = sw_wr && sw_addr == SW_DWRITE;
  wire dreadq = sw_wr && sw_addr == SW_DREAD;

  assign busy = state != S_IDLE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dual      <= 1'b0;
      subclass1 <= 1'b0;
      daddr     <= 12'h000;
    end else begin
      if (sw_wr && sw_addr == SW_CTRL && !busy) begin
        dual      <= sw_wdata[1];
        subclass1 <= sw_wdata[2];
      end
      if (sw_wr && sw_addr == SW_DADDR)
        daddr <= sw_wdata[11:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state          <= S_IDLE;
      link.cfg_addr  <= 12'h000;
      link.cfg_wdata <= 8'h00;
      link.cfg_wr    <= 1'b0;
      link.cfg_rd    <= 1'b0;
      link.sysref    <= 1'b0;
      done           <= 1'b0;
      dread          <= 8'h00;
      dread_valid    <= 1'b0;
      wait_cnt       <= '0;
    end else begin
      link.cfg_wr <= 1'b0;
      link.cfg_rd <= 1'b0;
      link.sysref <= 1'b0;
      case (state)
        S_IDLE: begin
          // Commands during a sequence are dropped; busy shows why
          if (start) begin
            done  <= 1'b0;
            state <= S_SYNCDRV;
          end else if (dwrite) begin
            link.cfg_addr  <= daddr;
            // Main config bit 0 must stay clear whatever software sends
            link.cfg_wdata <= daddr == A_MAIN_CFG ? sw_wdata[7:0] & 8'hFE : sw_wdata[7:0];
            link.cfg_wr    <= 1'b1;
          end else if (dreadq) begin
            link.cfg_addr <= daddr;
            link.cfg_rd   <= 1'b1;
            dread_valid   <= 1'b0;
            state         <= S_DRD_W;
          end
        end
        S_DRD_W: state <= S_DRD_C;
        S_DRD_C: begin
          dread       <= link.cfg_rdata;
          dread_valid <= 1'b1;
          state       <= S_IDLE;
        end
        S_SYNCDRV: begin
          link.cfg_addr  <= A_SYNC_DRV;
          link.cfg_wdata <= dual ? V_SYNCDRV_DUAL : V_SYNCDRV_SINGLE;
          link.cfg_wr    <= 1'b1;
          state          <= S_PWR;
        end
        S_PWR: begin
          link.cfg_addr  <= A_SERDES_PWR;
          link.cfg_wdata <= V_SERDES_ON;
          link.cfg_wr    <= 1'b1;
          wait_cnt       <= '0;
          state          <= S_WAIT;
        end
        S_WAIT: begin
          wait_cnt <= wait_cnt + 23'd1;
          if (wait_cnt == 23'(WAIT_CYCLES - 1))
            state <= S_PLL0;
        end
        S_PLL0: begin
          link.cfg_addr  <= A_PLL_CTRL;
          link.cfg_wdata <= V_PLL_START0;
          link.cfg_wr    <= 1'b1;
          state          <= S_PLL1;
        end
        S_PLL1: begin
          link.cfg_wdata <= V_PLL_START1;
          link.cfg_wr    <= 1'b1;
          state          <= S_POLL;
        end
        S_POLL: begin
          link.cfg_addr <= A_PLL_STAT;
          link.cfg_rd   <= 1'b1;
          state         <= S_POLL_W;
        end
        S_POLL_W: state <= S_POLL_C;
        S_POLL_C: state <= link.cfg_rdata[PLL_LOCK_BIT] ? S_ROT : S_POLL;
        S_ROT: begin
          link.cfg_addr  <= A_ROTATION;
          link.cfg_wdata <= V_ROTATION;
          link.cfg_wr    <= 1'b1;
          state          <= S_MODE;
        end
        S_MODE: begin
          link.cfg_addr  <= A_SYNC_MODE;
          link.cfg_wdata <= V_ONESHOT;
          link.cfg_wr    <= 1'b1;
          state          <= S_SYSREF;
        end
        S_SYSREF: begin
          link.sysref <= subclass1;
          state       <= S_LINK;
        end
        S_LINK: begin
          link.cfg_addr  <= A_LINK_CTRL;
          link.cfg_wdata <= dual ? V_LINK_DUAL : V_LINK_SINGLE;
          link.cfg_wr    <= 1'b1;
          done           <= 1'b1;
          state          <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      sw_rdata <= 16'h0000;
    else if (sw_rd) begin
      case (sw_addr)
        SW_CTRL:  sw_rdata <= {10'h000, link.sync_req_n, subclass1, dual, done, busy};
        SW_DADDR: sw_rdata <= {4'h0, daddr};
        SW_DREAD: sw_rdata <= {7'h00, dread_valid, dread};
        default:  sw_rdata <= 16'h0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/dac_setup_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dac_setup_asserts
  import dac_setup_pkg::*;
(
  input wire logic        clk,        // Clock
  input wire logic        sys_rst,    // Reset
  input wire logic [11:0] cfg_addr,   // Address
  input wire logic [7:0]  cfg_wdata,  // Write data
  input wire logic        cfg_wr,     // Write strobe
  input wire logic        cfg_rd,     // Read strobe
  input wire logic [7:0]  cfg_rdata,  // Read data
  input wire logic        sysref,     // Alignment pulse
  input wire logic [1:0]  sync_req_n, // Requests
  input wire logic [1:0]  sync_req_oe // Driver enables
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_pll_start: assert property (cfg_wr && cfg_addr == A_PLL_CTRL && cfg_wdata == 8'h05
    |=> cfg_wr && cfg_addr == A_PLL_CTRL && cfg_wdata == 8'h01) else $error("pll start order");
  chk_serdes_quiet: assert property (cfg_wr && cfg_addr == A_SERDES_PWR |=> !cfg_wr [*8])
    else $error("write during serdes wait");
  chk_serdes_wait: assert property (cfg_wr && cfg_addr == A_SERDES_PWR
    |-> ##[20:30] (cfg_wr && cfg_addr == A_PLL_CTRL)) else $error("pll start late");
  chk_lock_seen: assert property (cfg_wr && cfg_addr == A_ROTATION |-> cfg_rdata[0])
    else $error("setup went on without lock");
  chk_oneshot_next: assert property (cfg_wr && cfg_addr == A_ROTATION && cfg_wdata == 8'hF1
    |=> cfg_wr && cfg_addr == A_SYNC_MODE && cfg_wdata == 8'h02) else $error("one-shot not armed");
  chk_sysref_armed: assert property ($rose(sysref) |-> $past(cfg_wr && cfg_addr == A_SYNC_MODE))
    else $error("sysref before arming");
  chk_sync_oe: assert property (cfg_wr && cfg_addr == A_SYNC_DRV
    |-> ##2 sync_req_oe == ~{$past(cfg_wdata[0], 2), $past(cfg_wdata[1], 2)}) else $error("driver enable wrong");
  chk_link_req: assert property (cfg_wr && cfg_addr == A_LINK_CTRL
    |-> ##2 sync_req_n == ~$past(cfg_wdata[1:0], 2)) else $error("request level wrong");
endmodule
`default_nettype wire

// ### tb/test_dac_datapath_link_setup_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_dac_datapath_link_setup_regs;
  import dac_setup_pkg::*;
  logic                      clk = 1'b0;
  logic                      sys_rst = 1'b1;
  logic                      lock = 1'b0;
  logic [3:0]                sw_addr = 4'h0;
  logic [15:0]               sw_wdata = 16'h0000;
  logic                      sw_wr = 1'b0;
  logic                      sw_rd = 1'b0;
  logic [15:0]               sw_rdata;
  logic                      busy;
  logic [NUM_CH-1:0][11:0]   gain;
  logic [NUM_PATH-1:0][47:0] ftw;
  logic [NUM_LANE-1:0][2:0]  src;
  int                        n_errors = 0;
  int                        checks = 0;
  dac_setup_if link_if();
  dac_setup_regs dac_setup_regs_i (.clk(clk), .sys_rst(sys_rst), .link(link_if.dev), .serdes_pll_locked(lock),
    .link_synced(2'b00), .ch_gain(gain), .ch_test_tone(), .nco_en(), .nco_mod_en(), .nco_lower_sb(), .nco_ftw(ftw),
    .nco_phase(), .nco_modulus(), .nco_delta(), .lane_pd(), .serdes_pwr(), .serdes_pll_ctrl(), .sync_out_lvds(),
    .lane_source(src), .link_dual(), .link_page(), .link_enable(), .sync_align(), .port_enable(), .txen_feature());
  // Short wait keeps the run small; the checker bounds assume this value
  dac_setup_sequencer #(.WAIT_CYCLES(20)) dac_setup_sequencer_i (.clk(clk), .sys_rst(sys_rst), .link(link_if.host),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .busy(busy));
  dac_setup_asserts dac_setup_asserts_i (.clk(clk), .sys_rst(sys_rst), .cfg_addr(link_if.cfg_addr),
    .cfg_wdata(link_if.cfg_wdata), .cfg_wr(link_if.cfg_wr), .cfg_rd(link_if.cfg_rd), .cfg_rdata(link_if.cfg_rdata),
    .sysref(link_if.sysref), .sync_req_n(link_if.sync_req_n), .sync_req_oe(link_if.sync_req_oe));
  task automatic stop_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic sw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic idle(input int lim);
    #1;
    for (int i = 0; i < lim && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (busy !== 1'b0) begin
      $display("[FAIL] %0t got %h exp %h", $time, busy, 1'b0);
      n_errors++;
      stop_test;
    end
  endtask
  task automatic dw(input logic [11:0] a, input logic [7:0] d);
    sw(SW_DADDR, {4'h0, a});
    sw(SW_DWRITE, {8'h00, d});
    idle(50);
    // Device write lands one edge after the sequencer issues it
    @(posedge clk);
    #1;
  endtask
  task automatic dr(input logic [11:0] a, input logic [7:0] e);
    sw(SW_DADDR, {4'h0, a});
    sw(SW_DREAD, 16'h0000);
    idle(50);
    @(posedge clk);
    sw_addr <= SW_DREAD;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    cmp({32'h0, sw_rdata}, {32'h0, 8'h01, e});
  endtask
  initial forever #10 clk = ~clk;
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    dr(A_PAGE, PAGE_RST);
    dr(12'hFFF, 8'h00);
    dw(A_PLL_STAT, 8'hFF);
    dr(A_PLL_STAT, 8'h00);
    dw(A_PAGE, 8'h05);
    for (int i = 0; i < 6; i++) dw(A_CH_FTW + 12'(i), 8'(8'h11 * (i + 1)));
    cmp(ftw[0], 48'h0);
    dw(A_CH_UPD, 8'h01);
    cmp(ftw[0], 48'h665544332211);
    cmp(ftw[2], 48'h665544332211);
    cmp(ftw[1], 48'h0);
    dw(A_CH_GAIN, 8'h34);
    dw(A_CH_GAIN + 12'h001, 8'h0A);
    cmp(48'(gain[2]), 48'hA34);
    cmp(48'(gain[1]), 48'(GAIN_RST));
    dw(A_XBAR + 12'h003, 8'h2B);
    cmp(48'({src[7], src[6]}), 48'h2B);
    dw(A_CH_MOD + 12'h005, 8'h5A);
    dr(A_CH_MOD + 12'h005, 8'h5A);
    dw(A_PAGE, 8'h40);
    dw(A_MAIN_CFG, 8'h0F);
    dr(A_MAIN_CFG, 8'h0E);
    dw(A_PAGE, 8'h80);
    dr(A_MAIN_CFG, MAIN_CFG_RST);
    dw(A_LANE_PD, 8'hF0);
    dr(A_LANE_PD, 8'hF0);
    dw(A_SYNC_FMT0, 8'h00);
    dr(A_SYNC_FMT0, 8'h00);
    sw(SW_CTRL, 16'h0005);
    // Lock comes late so the status poll must loop
    repeat (40) @(posedge clk);
    lock <= 1'b1;
    #1;
    cmp(48'(busy), 48'h1);
    idle(100);
    dr(A_ROTATION, V_ROTATION);
    dr(A_SYNC_MODE, 8'h10);
    dr(A_LINK_CTRL, V_LINK_SINGLE);
    sw(SW_CTRL, 16'h0003);
    idle(100);
    dr(A_LINK_CTRL, V_LINK_DUAL);
    dr(A_SYNC_DRV, V_SYNCDRV_DUAL);
    stop_test;
  end
endmodule
`default_nettype wire
